// File: common/isr_pkg.sv
/*
  Package for the instrument status reporting block: command codes,
  register widths, bit positions, reset values and queue sizes.
  Assumes a single system clock and one command source.
*/
package isr_pkg;
  localparam int STD_W = 8;
  localparam int QUES_W = 16;
  localparam int DATA_W = 16;
  localparam int ERRQ_DEPTH = 20;
  localparam int ERR_MSG_CHARS = 80;
  // Standard event bit positions
  localparam int STD_OPC = 0;
  localparam int STD_QYE = 2;
  localparam int STD_DDE = 3;
  localparam int STD_EXE = 4;
  localparam int STD_CME = 5;
  localparam int STD_PON = 7;
  localparam logic [7:0] STD_USED = 8'hbd;
  localparam logic [7:0] STD_RST = 8'h80;
  // Questionable data bit positions
  localparam int QUES_VOLT = 0;
  localparam int QUES_CURR = 1;
  localparam int QUES_OHM = 9;
  localparam int QUES_LO = 11;
  localparam int QUES_HI = 12;
  localparam logic [15:0] QUES_USED = 16'h1a03;
  localparam logic [15:0] QUES_RST = 16'h0000;
  localparam logic [15:0] QEN_RST = 16'h0000;
  localparam logic [7:0] ESE_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;
  // Status byte bit positions
  localparam int STB_QUES = 3;
  localparam int STB_MAV = 4;
  localparam int STB_ESB = 5;
  localparam int STB_RQS = 6;
  localparam logic [15:0] OPC_REPLY = 16'h0001;
  localparam logic [15:0] ERR_NONE = 16'h0000;

  typedef enum logic [3:0] {
    CMD_CLS = 4'b0000,
    CMD_ESE_W = 4'b0001,
    CMD_ESE_Q = 4'b0010,
    CMD_ESR_Q = 4'b0011,
    CMD_OPC = 4'b0100,
    CMD_OPC_Q = 4'b0101,
    CMD_PSC_W = 4'b0110,
    CMD_PSC_Q = 4'b0111,
    CMD_SRE_W = 4'b1000,
    CMD_SRE_Q = 4'b1001,
    CMD_STB_Q = 4'b1010,
    CMD_QEN_W = 4'b1011,
    CMD_QEN_Q = 4'b1100,
    CMD_QEV_Q = 4'b1101,
    CMD_PRESET = 4'b1110,
    CMD_ERR_Q = 4'b1111
  } isr_cmd_t;

  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } isr_state_t;
endpackage : isr_pkg

// File: design/isr_err_fifo.sv
/*
  Error queue: first-in first-out store of error codes.
  Assumes push and pop come from logic on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_err_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic push_valid,
  input wire logic [WIDTH-1:0] push_data,
  output logic push_ready,
  input wire logic pop_req,
  output logic head_valid,
  output logic [WIDTH-1:0] head_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic do_push;
  logic do_pop;

  assign push_ready = (cnt_reg != CW'(DEPTH));
  assign head_valid = (cnt_reg != '0);
  assign head_data = mem[rd_reg];
  // New errors beyond the depth are dropped
  assign do_push = push_valid && push_ready;
  assign do_pop = pop_req && head_valid;

  function automatic logic [AW-1:0] isr_wrap(input logic [AW-1:0] p);
    isr_wrap = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : isr_wrap

  always_ff @(posedge clk_sys) begin
    if (do_push) begin
      mem[wr_reg] <= push_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= isr_wrap(wr_reg);
      end
      if (do_pop) begin
        rd_reg <= isr_wrap(rd_reg);
      end
      cnt_reg <= cnt_reg + CW'(do_push) - CW'(do_pop);
    end
  end

  fifo_bound_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst) cnt_reg <= CW'(DEPTH))
    else $error("error queue count above depth");
endmodule : isr_err_fifo
`default_nettype wire

// File: design/isr_status_regs.sv
/*
  Status reporting registers: standard event and questionable data
  event registers with enable masks, status byte, service request,
  power-on status clear setting and error queue, driven by decoded
  status commands.
  Assumes a command decoder, the measurement logic and non-volatile
  storage all on clk_sys; the formatter turns reply values into text.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_status_regs #(
  parameter int ERR_DEPTH = isr_pkg::ERRQ_DEPTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire isr_pkg::isr_cmd_t cmd_code,
  input wire logic [15:0] cmd_arg,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic ops_idle,
  input wire logic ev_query_empty,
  input wire logic ev_query_unread,
  input wire logic ev_query_full,
  input wire logic ev_selftest_err,
  input wire logic ev_cal_err,
  input wire logic ev_exec_err,
  input wire logic ev_syntax_err,
  input wire logic [15:0] err_code,
  input wire logic ovl_volt,
  input wire logic ovl_curr,
  input wire logic ovl_ohm,
  input wire logic limit_test_on,
  input wire logic limit_low,
  input wire logic limit_high,
  input wire logic msg_avail,
  input wire logic spoll_req,
  output logic [7:0] spoll_data,
  output logic srq_out,
  input wire logic nv_psc,
  input wire logic [7:0] nv_ese,
  input wire logic [7:0] nv_sre,
  output logic nv_save,
  output logic nv_psc_val,
  output logic [7:0] nv_ese_val,
  output logic [7:0] nv_sre_val
);
  isr_pkg::isr_state_t state_reg;
  logic [7:0] std_reg;
  logic [15:0] ques_reg;
  logic [7:0] ese_reg;
  logic [7:0] sre_reg;
  logic [15:0] qen_reg;
  logic psc_reg;
  logic rqs_reg;
  logic svc_prev_reg;
  logic rsp_valid_reg;
  logic [15:0] rsp_data_reg;
  logic [7:0] spoll_reg;
  logic nv_save_reg;
  logic take;
  logic [7:0] std_set;
  logic [15:0] ques_set;
  logic [7:0] std_next;
  logic [15:0] ques_next;
  logic std_sum;
  logic ques_sum;
  logic [7:0] stb_core;
  logic [7:0] stb_full;
  logic svc;
  logic svc_rise;
  logic err_any;
  logic errq_head_valid;
  logic [15:0] errq_head;
  logic [15:0] rsp_next;

  function automatic logic isr_hit(
    input logic t,
    input isr_pkg::isr_cmd_t code,
    input isr_pkg::isr_cmd_t want
  );
    isr_hit = t && (code == want);
  endfunction : isr_hit

  ////////////////////////////////////////////////////////////////////
  // Command acceptance

  // Completion commands wait for all earlier work to finish
  always_comb begin
    cmd_ready = (state_reg == isr_pkg::ST_RUN);
    if ((cmd_code == isr_pkg::CMD_OPC) ||
        (cmd_code == isr_pkg::CMD_OPC_Q)) begin
      cmd_ready = cmd_ready && ops_idle;
    end
  end

  assign take = cmd_valid && cmd_ready;

  // One cycle after reset the stored settings are loaded
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= isr_pkg::ST_INIT;
    end else begin
      state_reg <= isr_pkg::ST_RUN;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Standard event register

  always_comb begin
    std_set = '0;
    std_set[isr_pkg::STD_OPC] = isr_hit(take, cmd_code, isr_pkg::CMD_OPC);
    std_set[isr_pkg::STD_QYE] = ev_query_empty || ev_query_unread ||
                                ev_query_full;
    std_set[isr_pkg::STD_DDE] = ev_selftest_err || ev_cal_err ||
                                ovl_volt || ovl_curr || ovl_ohm;
    std_set[isr_pkg::STD_EXE] = ev_exec_err;
    std_set[isr_pkg::STD_CME] = ev_syntax_err;
  end

  // A set in the clearing cycle survives the clear
  always_comb begin
    std_next = std_reg;
    if (isr_hit(take, cmd_code, isr_pkg::CMD_CLS) ||
        isr_hit(take, cmd_code, isr_pkg::CMD_ESR_Q)) begin
      std_next = '0;
    end
    std_next = (std_next | std_set) & isr_pkg::STD_USED;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      std_reg <= isr_pkg::STD_RST;
    end else begin
      std_reg <= std_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Questionable data event register

  always_comb begin
    ques_set = '0;
    ques_set[isr_pkg::QUES_VOLT] = ovl_volt;
    ques_set[isr_pkg::QUES_CURR] = ovl_curr;
    ques_set[isr_pkg::QUES_OHM] = ovl_ohm;
    ques_set[isr_pkg::QUES_LO] = limit_test_on && limit_low;
    ques_set[isr_pkg::QUES_HI] = limit_test_on && limit_high;
  end

  always_comb begin
    ques_next = ques_reg;
    if (isr_hit(take, cmd_code, isr_pkg::CMD_CLS) ||
        isr_hit(take, cmd_code, isr_pkg::CMD_QEV_Q)) begin
      ques_next = '0;
    end
    ques_next = (ques_next | ques_set) & isr_pkg::QUES_USED;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ques_reg <= isr_pkg::QUES_RST;
    end else begin
      ques_reg <= ques_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enable masks and power-on clear setting

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ese_reg <= isr_pkg::ESE_RST;
      sre_reg <= isr_pkg::SRE_RST;
    end else if (state_reg == isr_pkg::ST_INIT) begin
      ese_reg <= nv_psc ? isr_pkg::ESE_RST : nv_ese;
      sre_reg <= nv_psc ? isr_pkg::SRE_RST : nv_sre;
    end else begin
      if (isr_hit(take, cmd_code, isr_pkg::CMD_ESE_W)) begin
        ese_reg <= cmd_arg[7:0];
      end
      if (isr_hit(take, cmd_code, isr_pkg::CMD_SRE_W)) begin
        sre_reg <= cmd_arg[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      qen_reg <= isr_pkg::QEN_RST;
    end else if (isr_hit(take, cmd_code, isr_pkg::CMD_PRESET)) begin
      qen_reg <= '0;
    end else if (isr_hit(take, cmd_code, isr_pkg::CMD_QEN_W)) begin
      qen_reg <= cmd_arg;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      psc_reg <= 1'b0;
    end else if (state_reg == isr_pkg::ST_INIT) begin
      psc_reg <= nv_psc;
    end else if (isr_hit(take, cmd_code, isr_pkg::CMD_PSC_W)) begin
      psc_reg <= cmd_arg[0];
    end
  end

  // Storage is told to save after any change of a kept setting
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      nv_save_reg <= 1'b0;
    end else begin
      nv_save_reg <= isr_hit(take, cmd_code, isr_pkg::CMD_PSC_W) ||
                     isr_hit(take, cmd_code, isr_pkg::CMD_ESE_W) ||
                     isr_hit(take, cmd_code, isr_pkg::CMD_SRE_W);
    end
  end

  assign nv_save = nv_save_reg;
  assign nv_psc_val = psc_reg;
  assign nv_ese_val = ese_reg;
  assign nv_sre_val = sre_reg;

  ////////////////////////////////////////////////////////////////////
  // Status byte and service request

  assign std_sum = |(std_reg & ese_reg);
  assign ques_sum = |(ques_reg & qen_reg);

  always_comb begin
    stb_core = '0;
    stb_core[isr_pkg::STB_QUES] = ques_sum;
    stb_core[isr_pkg::STB_MAV] = msg_avail;
    stb_core[isr_pkg::STB_ESB] = std_sum;
    stb_full = stb_core;
    stb_full[isr_pkg::STB_RQS] = rqs_reg;
  end

  assign svc = |(stb_core & sre_reg);
  assign svc_rise = svc && !svc_prev_reg;

  // Poll clears only the request bit; a new request wins over it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rqs_reg <= 1'b0;
      svc_prev_reg <= 1'b0;
    end else begin
      svc_prev_reg <= svc;
      if (svc_rise) begin
        rqs_reg <= 1'b1;
      end else if (spoll_req) begin
        rqs_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      spoll_reg <= '0;
    end else if (spoll_req) begin
      spoll_reg <= stb_full;
    end
  end

  assign spoll_data = spoll_reg;
  assign srq_out = rqs_reg;

  ////////////////////////////////////////////////////////////////////
  // Error queue

  assign err_any = ev_query_empty || ev_query_unread || ev_query_full ||
                   ev_selftest_err || ev_cal_err || ev_exec_err ||
                   ev_syntax_err;

  isr_err_fifo #(
    .WIDTH(isr_pkg::DATA_W),
    .DEPTH(ERR_DEPTH)
  ) u_errq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .push_valid(err_any),
    .push_data(err_code),
    .push_ready(),
    .pop_req(isr_hit(take, cmd_code, isr_pkg::CMD_ERR_Q)),
    .head_valid(errq_head_valid),
    .head_data(errq_head)
  );

  ////////////////////////////////////////////////////////////////////
  // Query replies

  // Replies carry the plain binary value of the register
  always_comb begin
    case (cmd_code)
      isr_pkg::CMD_ESE_Q: rsp_next = {8'h00, ese_reg};
      isr_pkg::CMD_ESR_Q: rsp_next = {8'h00, std_reg};
      isr_pkg::CMD_OPC_Q: rsp_next = isr_pkg::OPC_REPLY;
      isr_pkg::CMD_PSC_Q: rsp_next = {15'h0000, psc_reg};
      isr_pkg::CMD_SRE_Q: rsp_next = {8'h00, sre_reg};
      isr_pkg::CMD_STB_Q: rsp_next = {8'h00, stb_full};
      isr_pkg::CMD_QEN_Q: rsp_next = qen_reg;
      isr_pkg::CMD_QEV_Q: rsp_next = ques_reg;
      isr_pkg::CMD_ERR_Q: rsp_next = errq_head_valid ? errq_head :
                                     isr_pkg::ERR_NONE;
      default: rsp_next = '0;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= '0;
    end else begin
      rsp_valid_reg <= 1'b0;
      if (take) begin
        case (cmd_code)
          isr_pkg::CMD_ESE_Q, isr_pkg::CMD_ESR_Q, isr_pkg::CMD_OPC_Q,
          isr_pkg::CMD_PSC_Q, isr_pkg::CMD_SRE_Q, isr_pkg::CMD_STB_Q,
          isr_pkg::CMD_QEN_Q, isr_pkg::CMD_QEV_Q,
          isr_pkg::CMD_ERR_Q: begin
            rsp_valid_reg <= 1'b1;
            rsp_data_reg <= rsp_next;
          end
          default: begin
            rsp_valid_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  opc_wait_a: assert property (
    cmd_valid && (cmd_code == isr_pkg::CMD_OPC) && !ops_idle |-> !cmd_ready)
    else $error("completion command taken while busy");

  opc_bit_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_OPC) |=> std_reg[isr_pkg::STD_OPC])
    else $error("operation complete bit not set");

  query_err_a: assert property (
    ev_query_full |=> std_reg[isr_pkg::STD_QYE])
    else $error("query error bit not set");

  device_err_a: assert property (
    ovl_ohm |=> std_reg[isr_pkg::STD_DDE] && ques_reg[isr_pkg::QUES_OHM])
    else $error("overload not reported");

  exec_cmd_err_a: assert property (
    (ev_exec_err |=> std_reg[isr_pkg::STD_EXE]) and
    (ev_syntax_err |=> std_reg[isr_pkg::STD_CME]))
    else $error("execution or command error bit missing");

  power_hold_a: assert property (
    std_reg[isr_pkg::STD_PON] && !isr_hit(take, cmd_code, isr_pkg::CMD_ESR_Q)
    && !isr_hit(take, cmd_code, isr_pkg::CMD_CLS) |=> std_reg[isr_pkg::STD_PON])
    else $error("power on bit lost");

  esr_clear_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_ESR_Q) && std_set == '0
    |=> rsp_valid && rsp_data[7:0] == $past(std_reg) && std_reg == '0)
    else $error("event query did not return and clear");

  ese_zero_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_ESE_W) && cmd_arg == '0
    |=> (ese_reg == 8'h00))
    else $error("event mask not cleared");

  limit_gate_a: assert property (
    !limit_test_on && ques_reg[isr_pkg::QUES_LO] == 1'b0
    |=> ques_reg[isr_pkg::QUES_LO] == 1'b0)
    else $error("limit bit set with limit test off");

  preset_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_PRESET) |=> qen_reg == '0)
    else $error("questionable mask not cleared");

  stb_query_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_STB_Q) && !spoll_req && !svc_rise
    |=> rsp_data[7:0] == $past(stb_full) && rqs_reg == $past(rqs_reg))
    else $error("status byte query wrong");

  opc_reply_a: assert property (
    isr_hit(take, cmd_code, isr_pkg::CMD_OPC_Q) |=> rsp_valid && rsp_data == 16'h0001)
    else $error("completion query reply wrong");

  poll_clear_a: assert property (
    spoll_req && !svc_rise |=> !srq_out && spoll_data == $past(stb_full))
    else $error("serial poll handling wrong");

  srq_raise_c: cover property (svc_rise ##1 srq_out ##[1:20] spoll_req);
  opc_wait_c: cover property (cmd_valid && !cmd_ready ##[1:20] take);
  errq_read_c: cover property (isr_hit(take, cmd_code, isr_pkg::CMD_ERR_Q)
    && errq_head_valid);
  ques_sum_c: cover property (ques_sum && qen_reg != '0);
endmodule : isr_status_regs
`default_nettype wire

// File: bench/isr_ctrl_model.sv
/*
  Remote controller model: issues decoded status commands one at a time.
  Assumes tasks are entered just after a rising clk_sys edge.
*/
`timescale 1ns/1ps
`default_nettype none
module isr_ctrl_model (
  input wire logic clk_sys,
  input wire logic cmd_ready,
  output logic cmd_valid,
  output isr_pkg::isr_cmd_t cmd_code,
  output logic [15:0] cmd_arg
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = isr_pkg::CMD_CLS;
    cmd_arg = 16'h0000;
  end
  // Holds the command until an edge that sees cmd_ready high
  task automatic send(input isr_pkg::isr_cmd_t c, input logic [15:0] a);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1) @(posedge clk_sys);
  endtask : send
  // Released argument lines show the inverse of the last value
  task automatic idle();
    cmd_valid <= 1'b0;
    cmd_arg <= ~cmd_arg;
  endtask : idle
endmodule : isr_ctrl_model
`default_nettype wire

// File: bench/instrument_status_reporting_tb.sv
/*
  Self-checking bench for the status registers; replies checked from a queue.
  Assumes one 10 MHz clock and asynchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module instrument_status_reporting_tb;
  logic clk_sys, sys_rst, ops_idle, limit_test_on, msg_avail, spoll_req, nv_psc;
  logic cmd_valid, cmd_ready, rsp_valid, srq_out, nv_save, nv_psc_val;
  logic [11:0] ev;
  logic [15:0] err_code, cmd_arg, rsp_data, qe;
  logic [15:0] ec [5];
  logic [7:0] nv_ese, nv_sre, spoll_data, r8, nv_ese_val, nv_sre_val;
  isr_pkg::isr_cmd_t cmd_code;
  logic [15:0] exp_q [$];
  logic [15:0] std_t [12] = '{16'h0004, 16'h0004, 16'h0004, 16'h0008, 16'h0008,
    16'h0010, 16'h0020, 16'h0008, 16'h0008, 16'h0008, 16'h0000, 16'h0000};
  logic [15:0] ques_t [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0001, 16'h0002, 16'h0200, 16'h0800, 16'h1000};
  int bad_count, n_tests;

  isr_ctrl_model ctrl (.clk_sys(clk_sys), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_arg(cmd_arg));
  isr_status_regs #(.ERR_DEPTH(4)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .ops_idle(ops_idle),
    .ev_query_empty(ev[0]), .ev_query_unread(ev[1]), .ev_query_full(ev[2]),
    .ev_selftest_err(ev[3]), .ev_cal_err(ev[4]), .ev_exec_err(ev[5]),
    .ev_syntax_err(ev[6]), .err_code(err_code), .ovl_volt(ev[7]), .ovl_curr(ev[8]),
    .ovl_ohm(ev[9]), .limit_test_on(limit_test_on), .limit_low(ev[10]),
    .limit_high(ev[11]), .msg_avail(msg_avail), .spoll_req(spoll_req),
    .spoll_data(spoll_data), .srq_out(srq_out), .nv_psc(nv_psc), .nv_ese(nv_ese),
    .nv_sre(nv_sre), .nv_save(nv_save), .nv_psc_val(nv_psc_val), .nv_ese_val(nv_ese_val),
    .nv_sre_val(nv_sre_val));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_tests++;
    if (got !== want) begin
      bad_count++;
      $display("FAIL %0t got %h expected %h", $time, got, want);
    end
  endtask : chk
  task automatic conclude();
    if (bad_count == 0 && n_tests > 0 && exp_q.size() == 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic qry(input isr_pkg::isr_cmd_t c, input logic [15:0] want);
    exp_q.push_back(want);
    ctrl.send(c, 16'h0000);
  endtask : qry
  task automatic pulse(input int i);
    ctrl.idle();
    ev[i] <= 1'b1;
    @(posedge clk_sys);
    ev <= '0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic rst(input logic psc);
    sys_rst <= 1'b1;
    nv_psc <= psc;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
  endtask : rst
  // Replies are matched oldest first against the noted expectations
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      qe = (exp_q.size() > 0) ? exp_q.pop_front() : ~rsp_data;
      chk(rsp_data, qe);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ops_idle = 1'b1;
    limit_test_on = 1'b1;
    msg_avail = 1'b0;
    spoll_req = 1'b0;
    nv_ese = 8'h5a;
    nv_sre = 8'h5a;
    ev = '0;
    err_code = 16'h0000;
    void'($urandom(76));
    rst(1'b1);
    qry(isr_pkg::CMD_ESR_Q, 16'h0080);
    qry(isr_pkg::CMD_ESR_Q, 16'h0000);
    qry(isr_pkg::CMD_ESE_Q, 16'h0000);
    qry(isr_pkg::CMD_QEN_Q, 16'h0000);
    qry(isr_pkg::CMD_PSC_Q, 16'h0001);
    // Error queue of four: a fifth error is dropped, empty reads give zero
    for (int i = 0; i < 5; i++) begin
      ec[i] = 16'(($urandom % 16'hfffe) + 1);
      err_code <= ec[i];
      pulse(6);
    end
    for (int i = 0; i < 4; i++) qry(isr_pkg::CMD_ERR_Q, ec[i]);
    qry(isr_pkg::CMD_ERR_Q, 16'h0000);
    ctrl.send(isr_pkg::CMD_CLS, 16'h0000);
    for (int i = 0; i < 12; i++) begin
      pulse(i);
      qry(isr_pkg::CMD_ESR_Q, std_t[i]);
      qry(isr_pkg::CMD_QEV_Q, ques_t[i]);
    end
    limit_test_on <= 1'b0;
    pulse(10);
    pulse(11);
    qry(isr_pkg::CMD_QEV_Q, 16'h0000);
    // Operation complete waits for earlier work to finish
    ctrl.idle();
    ops_idle <= 1'b0;
    @(posedge clk_sys);
    fork
      ctrl.send(isr_pkg::CMD_OPC, 16'h0000);
      begin
        repeat (4) @(posedge clk_sys);
        ops_idle <= 1'b1;
      end
    join
    qry(isr_pkg::CMD_ESR_Q, 16'h0001);
    qry(isr_pkg::CMD_OPC_Q, 16'h0001);
    // Summaries, service request and serial poll
    ctrl.send(isr_pkg::CMD_ESE_W, 16'h0028);
    ctrl.send(isr_pkg::CMD_QEN_W, 16'h0001);
    msg_avail <= 1'b1;
    pulse(7);
    qry(isr_pkg::CMD_STB_Q, 16'h0038);
    ctrl.send(isr_pkg::CMD_SRE_W, 16'h0020);
    ctrl.idle();
    repeat (3) @(posedge clk_sys);
    chk(16'(srq_out), 16'h0001);
    qry(isr_pkg::CMD_STB_Q, 16'h0078);
    ctrl.idle();
    spoll_req <= 1'b1;
    @(posedge clk_sys);
    spoll_req <= 1'b0;
    @(negedge clk_sys);
    chk(16'(spoll_data), 16'h0078);
    chk(16'(srq_out), 16'h0000);
    @(posedge clk_sys);
    qry(isr_pkg::CMD_STB_Q, 16'h0038);
    qry(isr_pkg::CMD_ESR_Q, 16'h0008);
    qry(isr_pkg::CMD_STB_Q, 16'h0018);
    qry(isr_pkg::CMD_QEV_Q, 16'h0001);
    qry(isr_pkg::CMD_STB_Q, 16'h0010);
    msg_avail <= 1'b0;
    qry(isr_pkg::CMD_QEN_Q, 16'h0001);
    ctrl.send(isr_pkg::CMD_QEN_W, 16'h0000);
    qry(isr_pkg::CMD_QEN_Q, 16'h0000);
    ctrl.send(isr_pkg::CMD_QEN_W, 16'h1a03);
    ctrl.send(isr_pkg::CMD_PRESET, 16'h0000);
    qry(isr_pkg::CMD_QEN_Q, 16'h0000);
    ctrl.send(isr_pkg::CMD_PSC_W, 16'h0000);
    qry(isr_pkg::CMD_PSC_Q, 16'h0000);
    r8 = 8'(($urandom % 8'hff) + 1);
    ctrl.send(isr_pkg::CMD_ESE_W, {8'h00, r8});
    ctrl.idle();
    @(negedge clk_sys);
    chk(16'(nv_save), 16'h0001);
    chk(16'(nv_ese_val), {8'h00, r8});
    @(posedge clk_sys);
    qry(isr_pkg::CMD_ESE_Q, {8'h00, r8});
    ctrl.send(isr_pkg::CMD_ESE_W, 16'h0000);
    qry(isr_pkg::CMD_ESE_Q, 16'h0000);
    ctrl.idle();
    @(posedge clk_sys);
    // Restart with the stored masks kept
    rst(1'b0);
    qry(isr_pkg::CMD_ESE_Q, 16'h005a);
    qry(isr_pkg::CMD_SRE_Q, 16'h005a);
    qry(isr_pkg::CMD_PSC_Q, 16'h0000);
    qry(isr_pkg::CMD_ESR_Q, 16'h0080);
    ctrl.idle();
    repeat (3) @(posedge clk_sys);
    chk(16'(nv_psc_val), 16'h0000);
    chk(16'(nv_sre_val), 16'h005a);
    conclude();
  end
endmodule : instrument_status_reporting_tb
`default_nettype wire
